// file: shared/pitr_pkg.sv
/*
  constants for the power-management register target port: bus address,
  register offsets, per-variant and per-strap reset values, state encodings.
  assumes a single 250 mhz system clock and byte-wide registers.
*/
`default_nettype none

package pitr_pkg;

  // bus address and direction
  localparam logic [6:0] PITR_DEV_ADDR   = 7'h5b;
  localparam logic       PITR_DIR_WRITE  = 1'h0;
  localparam logic       PITR_DIR_READ   = 1'h1;
  localparam logic [7:0] PITR_READ_EMPTY = 8'hff;

  // clock and link figures
  localparam int         PITR_CLK_HZ     = 250000000;
  localparam int         PITR_MAX_BPS    = 1000000;
  localparam int         PITR_BIT_CYCLES = PITR_CLK_HZ / PITR_MAX_BPS;

  // register map
  localparam int         PITR_NREG       = 15;
  localparam int         PITR_NVARIANT   = 5;
  localparam logic [7:0] PITR_REG_OFFS [0:PITR_NREG-1] = '{
    8'h43, 8'h44, 8'h45,
    8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55,
    8'h60, 8'h61, 8'h62, 8'h63, 8'h64, 8'h65};

  // first and last index of the strap dependent ldo1 voltage registers
  localparam int         PITR_LDO1_FIRST = 3;
  localparam int         PITR_LDO1_LAST  = 6;

  // reset values per variant; ldo1 voltage slots come from the strap table
  localparam logic [7:0] PITR_VAR_DFLT [0:PITR_NVARIANT-1][0:PITR_NREG-1] = '{
    '{8'h61, 8'h24, 8'ha0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h09, 8'ha0,
      8'h37, 8'h37, 8'h37, 8'h37, 8'h01, 8'ha0},
    '{8'he3, 8'h2c, 8'ha0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h09, 8'ha0,
      8'h37, 8'h37, 8'h37, 8'h37, 8'h01, 8'ha0},
    '{8'hfd, 8'h1c, 8'ha0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h09, 8'ha0,
      8'h37, 8'h37, 8'h37, 8'h37, 8'h01, 8'ha0},
    '{8'he3, 8'h2c, 8'ha0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h09, 8'ha0,
      8'h99, 8'h99, 8'h99, 8'h99, 8'h1c, 8'ha0},
    '{8'h63, 8'h24, 8'ha0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h09, 8'ha0,
      8'h37, 8'h37, 8'h37, 8'h37, 8'h01, 8'ha0}};

  // three-level strap coding and the ldo1 voltages it selects
  localparam logic [1:0] PITR_SEL_LOW    = 2'h0;
  localparam logic [1:0] PITR_SEL_FLOAT  = 2'h1;
  localparam logic [1:0] PITR_SEL_HIGH   = 2'h2;
  localparam logic [7:0] PITR_LDO1_DFLT [0:2][0:3] = '{
    '{8'h99, 8'h99, 8'h19, 8'h99},
    '{8'ha7, 8'ha7, 8'h27, 8'ha7},
    '{8'hb7, 8'hb7, 8'h37, 8'hb7}};

  // count that load_cnt must pass after reset release; the strap is taken and the port opens on the 5th clock
  localparam logic [1:0] PITR_LOAD_CYCLES = 2'h3;

  // synchroniser idle value for scl, sda, strap and supply good
  localparam logic [4:0] PITR_SYNC_IDLE  = 5'h03;

  typedef enum {
    PITR_ST_IDLE,
    PITR_ST_RX,
    PITR_ST_ACK,
    PITR_ST_TX,
    PITR_ST_HACK,
    PITR_ST_WAIT
  } pitr_state_t;

  typedef enum {
    PITR_PH_ADDR,
    PITR_PH_CMD,
    PITR_PH_DATA
  } pitr_phase_t;

endpackage

`default_nettype wire

// file: design/pitr_sync.sv
/*
  three-stage input synchroniser with agreement filter.
  assumes inputs come from pins outside the clock domain; the output only
  changes once the second and third stages agree.
*/
`default_nettype none

module pitr_sync #(
  parameter int         WIDTH    = 1,
  parameter logic [WIDTH-1:0] IDLE = '0
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // pin side
  input  wire logic [WIDTH-1:0] d,
  // clock side
  output logic      [WIDTH-1:0] q
);
  import pitr_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } pitr_sync_t;

  pitr_sync_t r_reg;
  pitr_sync_t r_next;

  always_comb
  begin
    r_next    = r_reg;
    r_next.s1 = d;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (r_reg.s2[i] == r_reg.s3[i])
      begin
        r_next.q[i] = r_reg.s3[i];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      r_reg <= '{s1: IDLE, s2: IDLE, s3: IDLE, q: IDLE};
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  assign q = r_reg.q;

endmodule

`default_nettype wire

// file: design/pitr_target.sv
/*
  two-wire serial target port with the buck4, ldo1 and ldo2 register bank.
  assumes the host drives scl, the bus has external pull-ups, the system
  clock runs at 250 mhz, and the strap and supply-good inputs are pins.
*/
`default_nettype none

module pitr_target
  import pitr_pkg::*;
#(
  parameter int         VARIANT  = 0,
  parameter logic [6:0] DEV_ADDR = pitr_pkg::PITR_DEV_ADDR
) (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          reset_n,
  // serial clock, input only
  input  wire logic                          scl_in,
  output logic                               scl_out,
  output logic                               scl_oe,
  // serial data, open drain
  input  wire logic                          sda_in,
  output logic                               sda_out,
  output logic                               sda_oe,
  // straps and supply
  input  wire logic [1:0]                    ldo1_voltage_select_pin,
  input  wire logic                          supply_input_pin_good,
  // register contents and status
  output logic [pitr_pkg::PITR_NREG*8-1:0]   regs_q,
  output logic                               port_ready,
  output logic                               addressed
);
  import pitr_pkg::*;

  typedef struct packed {
    pitr_state_t                 state;
    pitr_phase_t                 phase;
    logic [3:0]                  bitcnt;
    logic [7:0]                  shift;
    logic                        rw;
    logic                        more;
    logic [7:0]                  ptr;
    logic                        sda_oe;
    logic [2:0]                  load_cnt;
    logic                        ready;
    logic                        scl_q;
    logic                        sda_q;
    logic [PITR_NREG-1:0][7:0]   regs;
  } pitr_core_t;

  pitr_core_t r_reg;
  pitr_core_t r_next;

  logic [4:0] pins_s;
  logic       scl_s;
  logic       sda_s;
  logic [1:0] sel_s;
  logic       supply_s;
  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;
  logic [4:0] hit;
  logic [7:0] rdata;

  // reset values for one strap level
  function automatic logic [PITR_NREG-1:0][7:0] dflt(input logic [1:0] sel);
    logic [PITR_NREG-1:0][7:0] v;
    int                        lvl;
    v   = '0;
    lvl = (sel == PITR_SEL_LOW) ? 0 : (sel == PITR_SEL_FLOAT) ? 1 : 2;
    for (int i = 0; i < PITR_NREG; i++)
    begin
      if (i >= PITR_LDO1_FIRST && i <= PITR_LDO1_LAST)
      begin
        v[i] = PITR_LDO1_DFLT[lvl][i-PITR_LDO1_FIRST];
      end
      else
      begin
        v[i] = PITR_VAR_DFLT[VARIANT][i];
      end
    end
    return v;
  endfunction

  // index lookup: valid flag over the storage index
  function automatic logic [4:0] lookup(input logic [7:0] a);
    logic [4:0] h;
    h = '0;
    for (int i = 0; i < PITR_NREG; i++)
    begin
      if (PITR_REG_OFFS[i] == a)
      begin
        h = {1'b1, 4'(i)};
      end
    end
    return h;
  endfunction

  // pin synchronisers
  pitr_sync #(
    .WIDTH (5),
    .IDLE  (PITR_SYNC_IDLE)
  ) u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .d       ({supply_input_pin_good, ldo1_voltage_select_pin, sda_in, scl_in}),
    .q       (pins_s)
  );

  assign scl_s    = pins_s[0];
  assign sda_s    = pins_s[1];
  assign sel_s    = pins_s[3:2];
  assign supply_s = pins_s[4];

  // edges and bus conditions; 250 clocks per bit leave wide margin
  assign scl_rise  = scl_s & ~r_reg.scl_q;
  assign scl_fall  = ~scl_s & r_reg.scl_q;
  assign bus_start = scl_s & r_reg.scl_q & r_reg.sda_q & ~sda_s;
  assign bus_stop  = scl_s & r_reg.scl_q & ~r_reg.sda_q & sda_s;

  // read data for the current index
  assign hit   = lookup(r_reg.ptr);
  assign rdata = hit[4] ? r_reg.regs[hit[3:0]] : PITR_READ_EMPTY;

  always_comb
  begin
    r_next       = r_reg;
    r_next.scl_q = scl_s;
    r_next.sda_q = sda_s;
    if (!r_reg.ready)
    begin
      // strap settles through the synchroniser, then defaults are taken;
      // one cycle past the count so the filtered strap has arrived
      if (r_reg.load_cnt > 3'(PITR_LOAD_CYCLES))
      begin
        r_next.regs  = dflt(sel_s);
        r_next.ready = 1'b1;
      end
      else
      begin
        r_next.load_cnt = r_reg.load_cnt + 3'h1;
      end
    end
    else if (!supply_s)
    begin
      // supply below lockout: release the bus, keep register contents
      r_next.state  = PITR_ST_IDLE;
      r_next.sda_oe = 1'b0;
    end
    else if (bus_start)
    begin
      // start or repeated start; index is kept across a repeated start
      r_next.state  = PITR_ST_RX;
      r_next.phase  = PITR_PH_ADDR;
      r_next.bitcnt = 4'h0;
      r_next.sda_oe = 1'b0;
    end
    else if (bus_stop)
    begin
      r_next.state  = PITR_ST_IDLE;
      r_next.sda_oe = 1'b0;
    end
    else
    begin
      case (r_reg.state)
        PITR_ST_RX:
        begin
          if (scl_rise && r_reg.bitcnt != 4'h8)
          begin
            r_next.shift  = {r_reg.shift[6:0], sda_s};
            r_next.bitcnt = r_reg.bitcnt + 4'h1;
          end
          else if (scl_fall && r_reg.bitcnt == 4'h8)
          begin
            r_next.state  = PITR_ST_ACK;
            r_next.sda_oe = 1'b1;
            case (r_reg.phase)
              PITR_PH_ADDR:
              begin
                if (r_reg.shift[7:1] == DEV_ADDR)
                begin
                  r_next.rw = r_reg.shift[0];
                end
                else
                begin
                  r_next.state  = PITR_ST_WAIT;
                  r_next.sda_oe = 1'b0;
                end
              end
              PITR_PH_CMD:
              begin
                r_next.ptr = r_reg.shift;
              end
              PITR_PH_DATA:
              begin
                if (hit[4])
                begin
                  r_next.regs[hit[3:0]] = r_reg.shift;
                end
              end
              default:
              begin
                r_next.state = PITR_ST_WAIT;
              end
            endcase
          end
        end
        PITR_ST_ACK:
        begin
          // ack is held through the whole ninth pulse, dropped after its fall
          if (scl_fall)
          begin
            r_next.bitcnt = 4'h0;
            if (r_reg.phase == PITR_PH_ADDR && r_reg.rw == PITR_DIR_READ)
            begin
              r_next.state  = PITR_ST_TX;
              r_next.shift  = rdata;
              r_next.sda_oe = ~rdata[7];
            end
            else
            begin
              r_next.state  = PITR_ST_RX;
              r_next.sda_oe = 1'b0;
              r_next.phase  = (r_reg.phase == PITR_PH_ADDR) ? PITR_PH_CMD : PITR_PH_DATA;
            end
          end
        end
        PITR_ST_TX:
        begin
          if (scl_fall)
          begin
            if (r_reg.bitcnt == 4'h7)
            begin
              r_next.state  = PITR_ST_HACK;
              r_next.sda_oe = 1'b0;
            end
            else
            begin
              r_next.bitcnt = r_reg.bitcnt + 4'h1;
              r_next.shift  = {r_reg.shift[6:0], 1'b0};
              r_next.sda_oe = ~r_reg.shift[6];
            end
          end
        end
        PITR_ST_HACK:
        begin
          if (scl_rise)
          begin
            r_next.more = ~sda_s;
          end
          else if (scl_fall)
          begin
            r_next.bitcnt = 4'h0;
            if (r_reg.more)
            begin
              r_next.state  = PITR_ST_TX;
              r_next.shift  = rdata;
              r_next.sda_oe = ~rdata[7];
            end
            else
            begin
              r_next.state  = PITR_ST_WAIT;
              r_next.sda_oe = 1'b0;
            end
          end
        end
        PITR_ST_IDLE,
        PITR_ST_WAIT:
        begin
          r_next.sda_oe = 1'b0;
        end
        default:
        begin
          r_next.state  = PITR_ST_IDLE;
          r_next.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      r_reg          <= '0;
      r_reg.state    <= PITR_ST_IDLE;
      r_reg.phase    <= PITR_PH_ADDR;
      r_reg.scl_q    <= 1'b1;
      r_reg.sda_q    <= 1'b1;
      r_reg.regs     <= dflt(PITR_SEL_LOW);
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // scl is never pulled low
  assign scl_out    = 1'b0;
  assign scl_oe     = 1'b0;
  assign sda_out    = 1'b0;
  assign sda_oe     = r_reg.sda_oe;
  assign regs_q     = r_reg.regs;
  assign port_ready = r_reg.ready;
  assign addressed  = (r_reg.state == PITR_ST_ACK) || (r_reg.state == PITR_ST_TX) ||
                      (r_reg.state == PITR_ST_HACK) ||
                      (r_reg.state == PITR_ST_RX && r_reg.phase != PITR_PH_ADDR);

endmodule

`default_nettype wire

// file: dv/pitr_host_model.sv
/*
  two-wire host model: start, stop and bit transfers at 160 ns per bit.
  assumes the bench resolves sda from all open-drain enables and a pull-up.
*/
`default_nettype none

module pitr_host_model (
  // bus pins
  output var logic scl,
  output var logic sda_low,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    scl = 1'h1;
    sda_low = 1'h0;
  end

  // start or repeated start, sda falls while scl high
  task automatic start();
    sda_low = 1'h0;
    #40 scl = 1'h1;
    #40 sda_low = 1'h1;
    #40 scl = 1'h0;
  endtask

  task automatic stop();
    sda_low = 1'h1;
    #40 scl = 1'h1;
    #40 sda_low = 1'h0;
    #40;
  endtask

  // one bit, sda sampled mid high phase
  task automatic bit_x(input logic b, output logic r);
    #40 sda_low = !b;
    #40 scl = 1'h1;
    #40 r = sda;
    #40 scl = 1'h0;
  endtask

  // byte msb first, then the ninth pulse; any number per frame
  task automatic byte_x(input logic [7:0] d, input logic ack_in, output logic [7:0] r, output logic ack_out);
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], r[i]);
    bit_x(ack_in, ack_out);
  endtask
endmodule

`default_nettype wire

// file: dv/pitr_target_sva.sv
/*
  port assertions for the register target: pin use, ack timing, load
  after reset, supply gating. assumes one clock and the top's ports only.
*/
`default_nettype none

module pitr_target_sva (
  // clock and reset
  input wire logic       clk,
  input wire logic       reset_n,
  // bus pins
  input wire logic       scl_in,
  input wire logic       scl_out,
  input wire logic       scl_oe,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  // straps and supply
  input wire logic [1:0] ldo1_voltage_select_pin,
  input wire logic       supply_input_pin_good,
  // status
  input wire logic [pitr_pkg::PITR_NREG*8-1:0] regs_q,
  input wire logic                             port_ready,
  input wire logic                             addressed
);
  timeunit 1ns;
  timeprecision 100ps;
  import pitr_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  AST_SCL_NEVER_DRIVEN:
    assert property (!scl_oe) else $error("scl driven");
  AST_SDA_PULLS_LOW_ONLY:
    assert property (sda_oe |-> !sda_out) else $error("sda driven high");
  AST_SDA_MOVES_IN_LOW:
    assert property (supply_input_pin_good && $changed(sda_oe) |-> !scl_in && $past(scl_in, 8))
      else $error("sda moved outside scl low");
  AST_SDA_STEADY_HIGH:
    assert property (supply_input_pin_good && $rose(scl_in) |-> ##1 $stable(sda_oe) [*8])
      else $error("sda moved during scl high");
  AST_READY_AFTER_RESET:
    assert property ($rose(reset_n) |-> !port_ready ##[2:6] port_ready) else $error("ready late");
  AST_READY_STAYS:
    assert property (port_ready |=> port_ready) else $error("ready dropped");
  AST_QUIET_UNTIL_READY:
    assert property (!port_ready |-> !sda_oe && !addressed) else $error("bus used before ready");
  AST_WRITE_WITH_ACK:
    assert property ($changed(regs_q) && $past(port_ready) |-> $rose(sda_oe)) else $error("write without ack");
  AST_SUPPLY_LOW_QUIET:
    assert property (!supply_input_pin_good [*6] |-> !sda_oe && !addressed) else $error("active without supply");
endmodule

bind pitr_target pitr_target_sva i_pitr_target_sva (
  .clk(clk), .reset_n(reset_n), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .ldo1_voltage_select_pin(ldo1_voltage_select_pin),
  .supply_input_pin_good(supply_input_pin_good), .regs_q(regs_q), .port_ready(port_ready), .addressed(addressed)
);

`default_nettype wire

// file: dv/pitr_target_bench.sv
/*
  bench for the register target: defaults, writes, unmapped indices,
  bursts and refusals. assumes variant index 3 and the host model.
*/
`default_nettype none

module pitr_target_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import pitr_pkg::*;

  localparam logic [6:0] ADDR = 7'h5b;
  localparam logic [7:0] OFFS [0:14] = '{8'h43, 8'h44, 8'h45, 8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55,
    8'h60, 8'h61, 8'h62, 8'h63, 8'h64, 8'h65};
  localparam logic [7:0] DFLT [0:14] = '{8'he3, 8'h2c, 8'ha0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h09, 8'ha0,
    8'h99, 8'h99, 8'h99, 8'h99, 8'h1c, 8'ha0};
  localparam logic [7:0] LDO1 [0:2][0:3] = '{'{8'h99, 8'h99, 8'h19, 8'h99},
    '{8'ha7, 8'ha7, 8'h27, 8'ha7}, '{8'hb7, 8'hb7, 8'h37, 8'hb7}};

  logic         clk, reset_n, scl, scl_w, scl_out, scl_oe;
  logic         sda_low, sda_w, sda_out, sda_oe;
  logic         supply_good, port_ready, addressed;
  logic [1:0]   ldo1_pin;
  logic [119:0] regs_q;
  logic [7:0]   exp_q [0:14];
  int           bad_count;
  int           n_tests;

  // wired bus with pull-ups
  assign scl_w = (scl_oe ? scl_out : 1'h1) & scl;
  assign sda_w = (sda_oe ? sda_out : 1'h1) & !sda_low;

  pitr_host_model i_pitr_host_model (.scl(scl), .sda_low(sda_low), .sda(sda_w));

  pitr_target #(.VARIANT(3), .DEV_ADDR(ADDR)) i_pitr_target (
    .clk(clk), .reset_n(reset_n), .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .ldo1_voltage_select_pin(ldo1_pin),
    .supply_input_pin_good(supply_good), .regs_q(regs_q), .port_ready(port_ready), .addressed(addressed)
  );

  initial
  begin
    clk = 1'h0;
    forever #2 clk = !clk;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] want);
    n_tests++;
    if (got !== want)
    begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // write a byte, want is the expected ack level
  task automatic wbyte(input logic [7:0] d, input logic want);
    logic [7:0] r;
    logic       a;
    i_pitr_host_model.byte_x(d, 1'h1, r, a);
    check({7'h0, a}, {7'h0, want});
  endtask

  task automatic rbyte(input logic ai, input logic [7:0] want);
    logic [7:0] r;
    logic       a;
    i_pitr_host_model.byte_x(8'hff, ai, r, a);
    check(r, want);
  endtask

  task automatic open_wr(input logic [7:0] idx);
    @(negedge clk);
    i_pitr_host_model.start();
    wbyte({ADDR, 1'h0}, 1'h0);
    wbyte(idx, 1'h0);
  endtask

  task automatic open_rd(input logic [7:0] idx);
    open_wr(idx);
    i_pitr_host_model.start();
    wbyte({ADDR, 1'h1}, 1'h0);
  endtask

  task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
    open_wr(idx);
    wbyte(d, 1'h0);
    i_pitr_host_model.stop();
  endtask

  task automatic rreg(input logic [7:0] idx, input logic [7:0] want);
    open_rd(idx);
    rbyte(1'h1, want);
    i_pitr_host_model.stop();
  endtask

  task automatic cmp_all();
    for (int i = 0; i < 15; i++)
      check(regs_q[i*8 +: 8], exp_q[i]);
  endtask

  task automatic do_reset(input logic [1:0] s);
    @(negedge clk);
    reset_n = 1'h0;
    ldo1_pin = s;
    repeat (6) @(negedge clk);
    check({7'h0, port_ready}, 8'h0);
    reset_n = 1'h1;
    for (int i = 0; i < 20 && port_ready !== 1'h1; i++)
      @(negedge clk);
    check({7'h0, port_ready}, 8'h1);
    repeat (10) @(negedge clk);
  endtask

  // defaults for each strap level, then all read back over the bus at the last (high) strap level only
  task automatic test_defaults();
    for (int s = 0; s < 3; s++)
    begin
      do_reset(s[1:0]);
      exp_q = DFLT;
      for (int j = 0; j < 4; j++)
        exp_q[3 + j] = LDO1[s][j];
      cmp_all();
    end
    for (int i = 0; i < 15; i++)
      rreg(OFFS[i], exp_q[i]);
  endtask

  // first and last register of the map
  task automatic test_write();
    wreg(8'h43, 8'h3c);
    wreg(8'h65, 8'hc3);
    exp_q[0] = 8'h3c;
    exp_q[14] = 8'hc3;
    cmp_all();
    rreg(8'h43, 8'h3c);
    rreg(8'h65, 8'hc3);
  endtask

  // unmapped indices: acked, no change, read as all ones
  task automatic test_unmapped();
    wreg(8'h46, 8'h00);
    wreg(8'h5f, 8'h00);
    wreg(8'h66, 8'h00);
    cmp_all();
    rreg(8'h46, 8'hff);
    rreg(8'h66, 8'hff);
  endtask

  // bursts on one index; sda left released after the final nack
  task automatic test_burst();
    open_wr(8'h44);
    check({7'h0, addressed}, 8'h1);
    wbyte(8'h11, 1'h0);
    wbyte(8'h22, 1'h0);
    wbyte(8'h33, 1'h0);
    i_pitr_host_model.stop();
    exp_q[1] = 8'h33;
    cmp_all();
    open_rd(8'h44);
    rbyte(1'h0, 8'h33);
    rbyte(1'h0, 8'h33);
    rbyte(1'h1, 8'h33);
    repeat (30) @(negedge clk);
    check({7'h0, sda_oe}, 8'h0);
    i_pitr_host_model.stop();
  endtask

  // each single-bit address error, then supply below lockout
  task automatic test_refuse();
    for (int i = 0; i < 7; i++)
    begin
      @(negedge clk);
      i_pitr_host_model.start();
      wbyte({ADDR ^ (7'h1 << i), 1'h0}, 1'h1);
      check({7'h0, addressed}, 8'h0);
      i_pitr_host_model.stop();
    end
    @(negedge clk);
    supply_good = 1'h0;
    repeat (10) @(negedge clk);
    i_pitr_host_model.start();
    wbyte({ADDR, 1'h1}, 1'h1);
    check({7'h0, addressed}, 8'h0);
    i_pitr_host_model.stop();
    @(negedge clk);
    supply_good = 1'h1;
    repeat (10) @(negedge clk);
    rreg(8'h44, 8'h33);
  endtask

  initial
  begin
    reset_n = 1'h0;
    ldo1_pin = 2'h0;
    supply_good = 1'h1;
    bad_count = 0;
    n_tests = 0;
    test_defaults();
    test_write();
    test_unmapped();
    test_burst();
    test_refuse();
    test_done();
  end

  // watchdog, well above the expected run
  initial
  begin
    #400000;
    bad_count++;
    test_done();
  end
endmodule

`default_nettype wire
